// ===== rtl/amc_edge_detect.sv
// Trigger edge detector selecting falling, rising or both edges
`timescale 1ns/1ps
module amc_edge_detect
(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             trig_in,
    input  wire amc_pkg::amc_edge_t edge_sel,
    output logic                  edge_hit
);
    import amc_pkg::*;

    logic prev_ff;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prev_ff <= 1'b0;
        else
            prev_ff <= trig_in;
    end

    always_comb
    begin
        unique case (edge_sel)
            AMC_EDGE_NONE: edge_hit = 1'b0;
            AMC_EDGE_FALL: edge_hit = prev_ff & ~trig_in;
            AMC_EDGE_RISE: edge_hit = ~prev_ff & trig_in;
            AMC_EDGE_BOTH: edge_hit = prev_ff ^ trig_in;
        endcase
    end
endmodule : amc_edge_detect

// ===== rtl/amc_pkg.sv
// Package: register map, field positions and timing constants
package amc_pkg;
    // ------------------------------------------------------------
    // Register addresses and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] MODE_ADDR    = 16'hff80;
    localparam logic [15:0] CHAN_ADDR    = 16'hff81;
    localparam logic [7:0]  MODE_RESET   = 8'h00;
    localparam logic [7:0]  CHAN_RESET   = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Mode register field positions, channel and result widths
    // ------------------------------------------------------------
    localparam int RUN_BIT   = 7;
    localparam int TRIG_BIT  = 6;
    localparam int TIME_HI   = 5;
    localparam int TIME_LO   = 3;
    localparam int EDGE_HI   = 2;
    localparam int EDGE_LO   = 1;
    localparam int BOOST_BIT = 0;
    localparam int CHAN_W    = 3;
    localparam int RES_W     = 10;
    localparam int RES_PAD   = 6;

    // ------------------------------------------------------------
    // Conversion lengths in main-clock cycles
    // ------------------------------------------------------------
    localparam logic [7:0] CYC_144 = 8'h90;
    localparam logic [7:0] CYC_120 = 8'h78;
    localparam logic [7:0] CYC_96  = 8'h60;
    localparam logic [7:0] CYC_72  = 8'h48;
    localparam logic [7:0] CYC_60  = 8'h3c;
    localparam logic [7:0] CYC_48  = 8'h30;

    typedef enum logic [1:0] {
        AMC_EDGE_NONE = 2'b00,
        AMC_EDGE_FALL = 2'b01,
        AMC_EDGE_RISE = 2'b10,
        AMC_EDGE_BOTH = 2'b11
    } amc_edge_t;

    typedef enum logic [1:0] {
        AMC_OP_STOP = 2'b00,
        AMC_OP_WAIT = 2'b01,
        AMC_OP_CONV_NOREF = 2'b10,
        AMC_OP_CONV = 2'b11
    } amc_op_t;
endpackage : amc_pkg

// ===== rtl/amc_top.sv
// Converter mode and channel control with conversion timing
//
// Summary of operation
// - Reset clears mode register to zero
// - Mode bit 7 stops or enables conversion
// - Mode bit 6 selects software or trigger start
// - Time code sets conversion cycles
// - Bits 2:1 select trigger edge
// - Bit 0 enables reference booster
// - Run and booster bits form four modes
// - Reset selects analog channel 0
// - Channel bits 2:0 give channel number
// - Mode bit writes allowed; channel byte only
// - Result in upper ten bits, low zero
// - Software start repeats conversions with interrupt
// - Trigger start converts once per edge seen while idle
// - Register write aborts conversion; software start restarts it
`timescale 1ns/1ps
module amc_top
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_wr,
    input  wire logic        bus_bit_wr,
    input  wire logic [2:0]  bus_bit_sel,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_rd,
    output logic      [7:0]  bus_rdata,
    input  wire logic        external_conversion_trigger,
    input  wire logic [9:0]  sar_value,
    output logic      [2:0]  channel_sel,
    output logic             sample_start,
    output logic             booster_on,
    output logic             converting,
    output amc_pkg::amc_op_t op_mode,
    output logic      [15:0] conversion_result,
    output logic             conversion_done_irq
);
    import amc_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]           mode_ff;
    logic [CHAN_W-1:0]    chan_ff;
    logic [7:0]           cnt_ff;
    logic                 busy_ff;
    logic                 done_ff;
    logic                 start_ff;
    logic [15:0]          result_ff;
    logic [7:0]           rdata_ff;
    logic                 mode_wr;
    logic                 chan_wr;
    logic                 any_wr;
    logic                 edge_hit;
    logic                 run;
    logic                 hw_start;
    logic                 start_now;
    logic [7:0]           nxt_mode;

    function automatic logic [7:0] time_cycles(input logic [2:0] code);
        unique case (code)
            3'b000:  time_cycles = CYC_144;
            3'b001:  time_cycles = CYC_120;
            3'b010:  time_cycles = CYC_96;
            3'b100:  time_cycles = CYC_72;
            3'b101:  time_cycles = CYC_60;
            3'b110:  time_cycles = CYC_48;
            // Prohibited codes fall back to the longest time
            default: time_cycles = CYC_144;
        endcase
    endfunction : time_cycles

    // Mode takes bit or byte writes, channel byte writes only
    assign mode_wr = (bus_wr | bus_bit_wr) && bus_addr == MODE_ADDR;
    assign chan_wr = bus_wr && bus_addr == CHAN_ADDR;
    assign any_wr  = mode_wr | chan_wr;
    assign run      = mode_ff[RUN_BIT];
    assign hw_start = mode_ff[TRIG_BIT];

    always_comb
    begin
        nxt_mode = mode_ff;
        if (bus_wr)
            nxt_mode = bus_wdata;
        else if (bus_bit_wr)
            nxt_mode[bus_bit_sel] = bus_wdata[0];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            mode_ff <= MODE_RESET;
        else if (mode_wr)
            mode_ff <= nxt_mode;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            chan_ff <= CHAN_RESET[CHAN_W-1:0];
        else if (chan_wr)
            chan_ff <= bus_wdata[CHAN_W-1:0];
    end

    // ------------------------------------------------------------
    // Trigger edge detection
    // ------------------------------------------------------------
    amc_edge_detect amc_edge_detect_inst
    (
        .clk      (clk),
        .arst_n   (arst_n),
        .trig_in  (external_conversion_trigger),
        .edge_sel (amc_edge_t'(mode_ff[EDGE_HI:EDGE_LO])),
        .edge_hit (edge_hit)
    );

    // ------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------
    // A write cycle never starts; in software start mode restart follows on the next cycle
    assign start_now = run && !any_wr &&
                       (hw_start ? (edge_hit && !busy_ff)
                                 : (!busy_ff || done_ff));

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy_ff <= 1'b0;
            cnt_ff  <= 8'h00;
        end
        else if (any_wr || !run)
        begin
            busy_ff <= 1'b0;
            cnt_ff  <= 8'h00;
        end
        else if (start_now)
        begin
            busy_ff <= 1'b1;
            cnt_ff  <= time_cycles(mode_ff[TIME_HI:TIME_LO])
                       - 8'h01;
        end
        else if (busy_ff && cnt_ff != 8'h00)
            cnt_ff <= cnt_ff - 8'h01;
        else if (busy_ff)
            busy_ff <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            done_ff <= 1'b0;
        else
            done_ff <= busy_ff && cnt_ff == 8'h01 &&
                       run && !any_wr;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            start_ff <= 1'b0;
        else
            start_ff <= start_now;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            result_ff <= RESULT_RESET;
        else if (done_ff)
            result_ff <= {sar_value, {RES_PAD{1'b0}}};
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_ff <= 8'h00;
        else if (bus_rd)
            rdata_ff <= bus_addr == MODE_ADDR ? mode_ff :
                        bus_addr == CHAN_ADDR ? {5'h00, chan_ff} : 8'h00;
    end

    assign bus_rdata           = rdata_ff;
    assign channel_sel         = chan_ff;
    assign sample_start        = start_ff;
    assign booster_on          = mode_ff[BOOST_BIT];
    assign converting          = busy_ff;
    assign op_mode             = amc_op_t'({run, mode_ff[BOOST_BIT]});
    assign conversion_result   = result_ff;
    assign conversion_done_irq = done_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_stop_idle: assert property (
        @(posedge clk) disable iff (!arst_n)
        !run |=> !busy_ff)
        else $error("busy while stopped");
    a_write_abort: assert property (
        @(posedge clk) disable iff (!arst_n)
        any_wr |=> !busy_ff)
        else $error("write did not abort");
    // Repeat must reload the counter, not merely keep busy high
    a_sw_repeat: assert property (
        @(posedge clk) disable iff (!arst_n)
        done_ff && run && !hw_start && !any_wr
        |=> busy_ff && cnt_ff != 8'h00)
        else $error("software mode did not repeat");
    // Limitation: a trigger in the last cycle is dropped while busy
    a_hw_once: assert property (
        @(posedge clk) disable iff (!arst_n)
        hw_start && busy_ff && cnt_ff == 8'h00 |=> !busy_ff)
        else $error("trigger mode converted twice");
    a_time_48: assert property (
        @(posedge clk) disable iff (!arst_n)
        start_now && mode_ff[TIME_HI:TIME_LO] == 3'b110
        |=> cnt_ff == 8'h2f)
        else $error("wrong conversion length");
    a_result_pad: assert property (
        @(posedge clk) disable iff (!arst_n)
        result_ff[RES_PAD-1:0] == 6'h00)
        else $error("result low bits set");
    a_chan_bus: assert property (
        @(posedge clk) disable iff (!arst_n)
        bus_bit_wr && !bus_wr && bus_addr == CHAN_ADDR
        |=> $stable(chan_ff))
        else $error("bit write changed channel");
    a_done_cnt: assert property (
        @(posedge clk) disable iff (!arst_n)
        done_ff |-> $past(busy_ff, 1))
        else $error("done without count");
endmodule : amc_top

// ===== tb/amc_front_model.sv
// Behavioural model of the analog front end and the trigger pin
`timescale 1ns/1ps
module amc_front_model
(
    input  wire logic       clk,
    input  wire logic [2:0] channel_sel,
    input  wire logic       sample_start,
    input  wire logic       trig_level,
    output logic      [9:0] sar_value,
    output logic            external_conversion_trigger
);
    // Value only changes on a new sample, so a stale channel shows up
    initial sar_value = 10'h3ff;
    initial external_conversion_trigger = 1'b0;
    always @(posedge clk)
    begin
        if (sample_start)
            sar_value <= {channel_sel, 7'h2a};
        external_conversion_trigger <= #1 trig_level;
    end
endmodule : amc_front_model

// ===== tb/test_adc_mode_channel_control.sv
// Testbench: register access, conversion timing, trigger and abort
`timescale 1ns/1ps
module test_adc_mode_channel_control;
    import amc_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, bus_wr = 1'b0, bus_bit_wr = 1'b0;
    logic bus_rd = 1'b0, trig_level = 1'b0, sample_start, booster_on;
    logic converting, conversion_done_irq, external_conversion_trigger;
    logic [15:0] bus_addr = 16'h0000, conversion_result;
    logic [7:0]  bus_wdata = 8'h00, bus_rdata, d;
    logic [2:0]  bus_bit_sel = 3'h0, channel_sel;
    logic [9:0]  sar_value;
    amc_op_t     op_mode;
    int mismatches = 0, tests_run = 0, n;
    int cyc[8] = '{144, 120, 96, 144, 72, 60, 48, 144};
    // Booster settling time of 14 us in 4 ns cycles
    localparam int BOOST_WAIT = 3500;
    always #2 clk = ~clk;
    amc_top amc_top_inst (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr), .bus_bit_sel(bus_bit_sel),
        .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .external_conversion_trigger(external_conversion_trigger),
        .sar_value(sar_value), .channel_sel(channel_sel),
        .sample_start(sample_start), .booster_on(booster_on),
        .converting(converting), .op_mode(op_mode),
        .conversion_result(conversion_result),
        .conversion_done_irq(conversion_done_irq));
    amc_front_model amc_front_model_inst (.clk(clk),
        .channel_sel(channel_sel), .sample_start(sample_start),
        .trig_level(trig_level), .sar_value(sar_value),
        .external_conversion_trigger(external_conversion_trigger));
    // ------------------------------------------------------------
    // Bus cycles and checks
    // ------------------------------------------------------------
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    // Each access ends with an idle edge so strobes never merge
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        bus_addr  = a;
        bus_wdata = v;
        bus_wr    = 1'b1;
        tick();
        bus_wr    = 1'b0;
        tick();
    endtask : wr
    task automatic bwr(input logic [15:0] a, input logic [2:0] b,
                       input logic v);
        bus_addr    = a;
        bus_bit_sel = b;
        bus_wdata   = {7'h00, v};
        bus_bit_wr  = 1'b1;
        tick();
        bus_bit_wr  = 1'b0;
        tick();
    endtask : bwr
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        bus_addr = a;
        bus_rd   = 1'b1;
        tick();
        bus_rd   = 1'b0;
        v        = bus_rdata;
        tick();
    endtask : rd
    task automatic cmp(input string s, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : cmp
    task automatic cmp_n(input string s, input int e, input int g);
        tests_run++;
        if (g != e)
        begin
            mismatches++;
            $display("[ERR] %s expected %0d seen %0d", s, e, g);
        end
    endtask : cmp_n
    // Bounded wait; a hang ends the run as a failure
    task automatic wait_irq(output int c);
        c = 1;
        tick();
        while (conversion_done_irq !== 1'b1 && c < 400)
        begin
            tick();
            c++;
        end
        if (conversion_done_irq !== 1'b1)
        begin
            mismatches++;
            summarize();
        end
    endtask : wait_irq
    task automatic quiet(input int c);
        n = 0;
        repeat (c)
        begin
            tick();
            if (conversion_done_irq !== 1'b0)
                n++;
        end
        cmp_n("stray irq", 0, n);
    endtask : quiet
    task automatic summarize;
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (3) @(posedge clk);
        #1 arst_n = 1'b1;
        rd(MODE_ADDR, d);
        cmp("mode", 16'h0000, d);
        rd(CHAN_ADDR, d);
        cmp("chan", 16'h0000, d);
        wr(CHAN_ADDR, 8'h05);
        rd(CHAN_ADDR, d);
        cmp("chan", 16'h0005, d);
        bwr(CHAN_ADDR, 3'h1, 1'b1);
        cmp("chsel", 16'h0005, channel_sel);
        bwr(MODE_ADDR, 3'h0, 1'b1);
        cmp("boost", 16'h0001, booster_on);
        cmp("op", 16'h0001, op_mode);
        repeat (BOOST_WAIT) tick();
        for (int k = 0; k < 8; k++)
        begin
            bwr(MODE_ADDR, 3'h7, 1'b0);
            wr(MODE_ADDR, {2'b10, k[2:0], 3'b001});
            // First period is partial, the second one is measured
            wait_irq(n);
            wait_irq(n);
            cmp_n("period", cyc[k], n);
        end
        cmp("op", 16'h0003, op_mode);
        tick();
        cmp("result", {3'h5, 7'h2a, 6'h00}, conversion_result);
        cmp("conv", 16'h0001, converting);
        wait_irq(n);
        repeat (50) tick();
        wr(CHAN_ADDR, 8'h03);
        wait_irq(n);
        cmp_n("abort", 1, n > 120);
        wait_irq(n);
        tick();
        cmp("result", {3'h3, 7'h2a, 6'h00}, conversion_result);
        bwr(MODE_ADDR, 3'h7, 1'b0);
        wr(MODE_ADDR, 8'h00);
        cmp("op", 16'h0000, op_mode);
        wr(MODE_ADDR, 8'h01);
        repeat (BOOST_WAIT) tick();
        wr(MODE_ADDR, 8'hc5);
        quiet(20);
        cmp("conv", 16'h0000, converting);
        trig_level = 1'b1;
        wait_irq(n);
        quiet(300);
        trig_level = 1'b0;
        quiet(200);
        wr(MODE_ADDR, 8'hc7);
        trig_level = 1'b1;
        wait_irq(n);
        tick();
        cmp("conv", 16'h0000, converting);
        trig_level = 1'b0;
        wait_irq(n);
        wr(MODE_ADDR, 8'hc3);
        trig_level = 1'b1;
        quiet(200);
        trig_level = 1'b0;
        wait_irq(n);
        wr(MODE_ADDR, 8'hc1);
        trig_level = 1'b1;
        quiet(50);
        wr(MODE_ADDR, 8'h00);
        wr(MODE_ADDR, 8'h80);
        cmp("start", 16'h0001, sample_start);
        cmp("op", 16'h0002, op_mode);
        // Without the booster the first result is thrown away
        wait_irq(n);
        wait_irq(n);
        tick();
        cmp("result", {3'h3, 7'h2a, 6'h00}, conversion_result);
        bwr(MODE_ADDR, 3'h7, 1'b0);
        quiet(200);
        cmp("conv", 16'h0000, converting);
        summarize();
    end
endmodule : test_adc_mode_channel_control
